// *** shared/fault_pkg.sv ***
`default_nettype none
package fault_pkg;

  // ==========================================================================
  // Clocking and hold time
  // ==========================================================================
  localparam int CLK_HZ          = 50_000_000;
  localparam int HOLD_TIME_MS    = 10;
  localparam int HOLD_CYCLES     = (HOLD_TIME_MS * CLK_HZ) / 1000;
  localparam int HOLD_CNT_W      = 20;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [11:0] DIAG_OFS     = 12'h008;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h00C;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h010;

  // Control register fields
  localparam int RUN_BIT           = 0;
  localparam int STOP_ON_FAULT_BIT = 1;
  localparam int RESTART_CTRL_BIT  = 2;
  localparam int INHIB_BIT = 3;
  localparam int CTRL_W    = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // Status, diagnostic and interrupt layout (one bit per fault)
  localparam int F_SYS   = 0;
  localparam int F_MAIN_UV  = 1;
  localparam int F_LOGIC_UV = 2;
  localparam int F_OT    = 3;
  localparam int F_SYNC  = 4;
  localparam int F_BST   = 5;
  localparam int F_VDS   = 6;
  localparam int FAULT_W = 7;
  localparam logic [FAULT_W-1:0] FAULT_RST = 7'h00;

  // Bridge
  localparam int GATES   = 6;
  localparam int PHASES  = 3;
  localparam int SYNC_W  = 15;

endpackage
`default_nettype wire

// *** shared/hold_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface hold_if;
  logic cond;
  logic rel_ok;
  logic hold;

  modport timer (input cond, input rel_ok, output hold);
  modport user  (output cond, output rel_ok, input hold);
endinterface
`default_nettype wire

// *** hdl/sync_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_bank #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // Two-stage synchroniser, one per bit
  // ==========================================================================
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        meta_q[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule // sync_bank
`default_nettype wire

// *** hdl/hold_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module hold_timer
  import fault_pkg::*;
#(
  parameter int HOLD_N = HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Condition and hold
  hold_if.timer     hif
);

  logic [HOLD_CNT_W-1:0] cnt_q;
  logic                  active_q;

  // ==========================================================================
  // Hold stays up while the condition lasts or the host is in reset,
  // then for HOLD_N cycles more
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q    <= '0;
      active_q <= 1'b0;
    end
    else if (hif.cond || (active_q && !hif.rel_ok))
    begin
      cnt_q    <= '0;
      active_q <= 1'b1;
    end
    else if (active_q)
    begin
      if (cnt_q == HOLD_CNT_W'(HOLD_N - 1))
        active_q <= 1'b0;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

  assign hif.hold = hif.cond || active_q;

endmodule // hold_timer
`default_nettype wire

// *** hdl/bridge_fault_response.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RULE1) A disable-all response forces every gate drive low.
// (RULE2) Stop-on-fault clear: bootstrap or drain-source fault turns off one gate until PWM on.
// (RULE3) Serial clear only by status or diagnostic read while inhibit is 0.
// (RULE4) Host demand reset: demand to zero, then a new nonzero demand.
// (RULE5) Host run reset: run bit to 0, then back to 1.
// (RULE6) Logic-regulator undervoltage, or overtemperature with stop-on-fault, held 10 ms after release.
// (RULE7) Latched sync loss and stop-on-fault bridge faults clear on zero demand, run 0, serial read.
// (RULE8) Main-supply undervoltage, restart-control 0: outputs stay on, fault latches, same clears.
// (RULE9) Stop-on-fault set: bootstrap, drain-source, overtemperature disable all and latch.
// (RULE10) Restart-control 1: sync loss stops and restarts motor, no latch.
// (RULE11) System error disables all, latches, clears run; outputs return when run set again.
module bridge_fault_response
  import fault_pkg::*;
#(
  parameter int HOLD_N = HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Fault detectors (asynchronous)
  input  wire logic                sys_err,
  input  wire logic                main_supply_uv,
  input  wire logic                logic_regulator_uv,
  input  wire logic                overtemp,
  input  wire logic                sync_lost,
  input  wire logic [PHASES-1:0]   bootstrap_uv,
  input  wire logic [GATES-1:0]    vds_ov,
  input  wire logic                host_reset_out_n,
  // Drive loop (same clock)
  input  wire logic [GATES-1:0]    pwm_on,
  input  wire logic                demand_zero,
  input  wire logic [GATES-1:0]    gate_in,
  // Responses
  output logic      [GATES-1:0]    gate_out,
  output logic                     run,
  output logic                     stop_restart,
  output logic                     irq
);

  // ==========================================================================
  // Synchronised fault inputs
  // ==========================================================================
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] syn;
  logic              s_sys;
  logic              s_main_uv;
  logic              s_logic_uv;
  logic              s_ot;
  logic              s_sync;
  logic              s_host_rst_n;
  logic [PHASES-1:0] s_bst;
  logic [GATES-1:0]  s_vds;

  assign raw = {vds_ov, bootstrap_uv, host_reset_out_n, sync_lost, overtemp,
                logic_regulator_uv, main_supply_uv, sys_err};

  sync_bank #(.W(SYNC_W)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw),
    .sync_out (syn)
  );

  assign s_sys    = syn[0];
  assign s_main_uv    = syn[1];
  assign s_logic_uv   = syn[2];
  assign s_ot         = syn[3];
  assign s_sync       = syn[4];
  assign s_host_rst_n = syn[5];
  assign s_bst        = syn[8:6];
  assign s_vds        = syn[SYNC_W-1:9];

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [CTRL_W-1:0]  ctrl_q;
  logic [FAULT_W-1:0] lat_q;
  logic [FAULT_W-1:0] irq_stat_q;
  logic [FAULT_W-1:0] irq_mask_q;
  logic [FAULT_W-1:0] status;
  logic [FAULT_W-1:0] status_prev_q;
  logic [FAULT_W-1:0] diag;
  logic [31:0]        prdata_q;
  logic               err_q;
  logic               sys_prev_q;
  logic               sys_dis_q;
  logic               stop_en;
  logic               restart_en;
  logic               inhibit;
  logic               setup;
  logic               access;
  logic               wr;
  logic               rd;
  logic               run_wr_one;
  logic               ser_clear;
  logic               host_clear;
  logic               sys_rise;
  logic               hold_all;
  logic               bst_any;
  logic               vds_any;
  logic               dis_all;
  logic [GATES-1:0]   pg_fault;
  logic [GATES-1:0]   gate_off_q;
  logic [GATES-1:0]   gate_q;
  logic [FAULT_W-1:0] lat_set;
  logic [FAULT_W-1:0] lat_clr;

  assign stop_en    = ctrl_q[STOP_ON_FAULT_BIT];
  assign restart_en = ctrl_q[RESTART_CTRL_BIT];
  assign inhibit = ctrl_q[INHIB_BIT];
  assign run     = ctrl_q[RUN_BIT];

  // ==========================================================================
  // APB slave: zero wait states, read data captured in the setup cycle
  // ==========================================================================
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  assign prdata = prdata_q;
  assign pslverr = access && err_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
      if (paddr == CTRL_OFS)
        prdata_q[CTRL_W-1:0] <= ctrl_q;
      else if (paddr == STATUS_OFS)
        prdata_q[FAULT_W-1:0] <= status;
      else if (paddr == DIAG_OFS)
        prdata_q[FAULT_W-1:0] <= diag;
      else if (paddr == IRQ_STAT_OFS)
        prdata_q[FAULT_W-1:0] <= irq_stat_q;
      else if (paddr == IRQ_MASK_OFS)
        prdata_q[FAULT_W-1:0] <= irq_mask_q;
      else
        err_q <= 1'b1;
    end
  end

  // A status or diagnostic read is the serial clear, unless inhibited
  assign ser_clear = rd && !inhibit && ((paddr == STATUS_OFS) || (paddr == DIAG_OFS)); // RULE3

  // Zero demand, a cleared run bit or a serial clear release the main-supply, sync and bridge latches
  assign host_clear = demand_zero || !run || ser_clear; // RULE7 RULE8

  // ==========================================================================
  // Control register; a fresh system error drops the run bit
  // ==========================================================================
  assign sys_rise   = s_sys && !sys_prev_q;
  assign run_wr_one = wr && (paddr == CTRL_OFS) && pstrb[0] && pwdata[RUN_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= CTRL_RST;
      sys_prev_q <= 1'b0;
    end
    else
    begin
      sys_prev_q <= s_sys;
      if (wr && (paddr == CTRL_OFS) && pstrb[0])
        ctrl_q <= pwdata[CTRL_W-1:0];
      // Fault wins over a run write in the same cycle; a later run write restarts even while the error stays high
      if (sys_rise)
        ctrl_q[RUN_BIT] <= 1'b0; // RULE11
    end
  end

  // System error keeps the bridge off until software sets run again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sys_dis_q <= 1'b0;
    else if (sys_rise)
      sys_dis_q <= 1'b1; // RULE11
    else if (run_wr_one)
      sys_dis_q <= 1'b0; // RULE11
  end

  // ==========================================================================
  // Supervisory hold after regulator trouble, or overtemperature under stop on fault
  // ==========================================================================
  hold_if hif ();

  assign hif.cond   = s_logic_uv || (stop_en && s_ot); // RULE6
  assign hif.rel_ok = s_host_rst_n;
  assign hold_all   = hif.hold;

  hold_timer #(.HOLD_N(HOLD_N)) u_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .hif     (hif)
  );

  // ==========================================================================
  // Latched faults; an event in the clearing cycle is kept
  // ==========================================================================
  assign bst_any = |s_bst;
  assign vds_any = |s_vds;

  always_comb
  begin
    lat_set             = '0;
    lat_set[F_SYS]      = s_sys;                        // RULE11
    lat_set[F_MAIN_UV]  = s_main_uv && !restart_en;     // RULE8
    lat_set[F_LOGIC_UV] = s_logic_uv;
    lat_set[F_OT]       = s_ot && stop_en;              // RULE9
    lat_set[F_SYNC]     = s_sync && !restart_en;        // RULE7
    lat_set[F_BST]      = bst_any && stop_en;           // RULE9
    lat_set[F_VDS]      = vds_any && stop_en;           // RULE9
    lat_clr             = {FAULT_W{host_clear}};
    lat_clr[F_SYS]      = 1'b0;                         // RULE11
    lat_clr[F_LOGIC_UV] = !hold_all;                    // RULE6
    lat_clr[F_OT]   = !hold_all;                     // RULE6
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lat_q <= FAULT_RST;
    else
      lat_q <= lat_set | (lat_q & ~lat_clr);
  end

  // Unlatched faults show their live condition
  always_comb
  begin
    status          = lat_q;
    status[F_MAIN_UV] = lat_q[F_MAIN_UV] | (restart_en && s_main_uv);
    status[F_OT]      = lat_q[F_OT] | s_ot;
    status[F_SYNC]    = lat_q[F_SYNC] | (restart_en && s_sync);
    status[F_BST]   = lat_q[F_BST] | bst_any;
    status[F_VDS]   = lat_q[F_VDS] | vds_any;
  end

  assign diag = {vds_any, bst_any, s_sync, s_ot, s_logic_uv, s_main_uv, s_sys};

  // ==========================================================================
  // Gate drive
  // ==========================================================================
  // Main-supply undervoltage is left out on purpose: outputs stay enabled
  assign dis_all = sys_dis_q || hold_all || lat_q[F_SYNC] || (restart_en && s_sync) // RULE8 RULE10
                || lat_q[F_BST] || lat_q[F_VDS] || lat_q[F_OT]
                || (stop_en && (bst_any || vds_any || s_ot));                          // RULE9

  assign stop_restart = restart_en && s_sync; // RULE10

  // Per-gate switch-off; even gates are high side and see bootstrap faults
  for (genvar g = 0; g < GATES; g++)
  begin : g_gate
    if (g % 2 == 0)
    begin : g_hi
      assign pg_fault[g] = s_vds[g] || s_bst[g/2];
    end
    else
    begin : g_lo
      assign pg_fault[g] = s_vds[g];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        gate_off_q[g] <= 1'b0;
      else if (!stop_en && pg_fault[g])
        gate_off_q[g] <= 1'b1; // RULE2
      else if (pwm_on[g] || stop_en)
        gate_off_q[g] <= 1'b0; // RULE2
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_q <= '0;
    else if (dis_all)
      gate_q <= '0; // RULE1
    else
      gate_q <= gate_in & ~gate_off_q & ~({GATES{!stop_en}} & pg_fault); // RULE2
  end

  assign gate_out = gate_q;

  // ==========================================================================
  // Interrupts: sticky on a rising status bit, write one to clear
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q    <= FAULT_RST;
      irq_mask_q    <= FAULT_RST;
      status_prev_q <= FAULT_RST;
    end
    else
    begin
      status_prev_q <= status;
      if (wr && (paddr == IRQ_MASK_OFS) && pstrb[0])
        irq_mask_q <= pwdata[FAULT_W-1:0];
      if (wr && (paddr == IRQ_STAT_OFS) && pstrb[0])
        irq_stat_q <= (irq_stat_q & ~pwdata[FAULT_W-1:0]) | (status & ~status_prev_q);
      else
        irq_stat_q <= irq_stat_q | (status & ~status_prev_q);
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

endmodule // bridge_fault_response
`default_nettype wire

// *** verif/bridge_fault_response_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module bridge_fault_response_props
  import fault_pkg::*;
#(
  parameter int HOLD_N = HOLD_CYCLES
) (
  // Clock, reset and bus
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [3:0]       pstrb,
  // Faults and responses
  input wire logic             sys_err,
  input wire logic             logic_regulator_uv,
  input wire logic             sync_lost,
  input wire logic [GATES-1:0] vds_ov,
  input wire logic [GATES-1:0] gate_out,
  input wire logic             run,
  input wire logic             stop_restart,
  input wire logic             irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Mirror of the response mode bits, taken at the bus write edge
  // ==========================================================================
  logic stop_q;
  logic restart_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_q    <= 1'b0;
      restart_q <= 1'b0;
    end
    else if (psel && penable && pwrite && pstrb[0] && paddr == CTRL_OFS)
    begin
      stop_q    <= pwdata[STOP_ON_FAULT_BIT];
      restart_q <= pwdata[RESTART_CTRL_BIT];
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_sys_run: assert property ($rose(sys_err) |-> ##[1:5] !run)
    else $error("run kept after system error");
  a_sys_off: assert property ($rose(sys_err) |-> ##[1:5] gate_out == '0)
    else $error("gates on after system error");
  a_vlr_off: assert property (logic_regulator_uv [*4] |-> gate_out == '0)
    else $error("gates on during regulator fault");
  a_vlr_hold: assert property (logic_regulator_uv [*4] ##1 !logic_regulator_uv |-> (gate_out == '0) [*8])
    else $error("hold released too early");
  a_stop_all: assert property ((stop_q && vds_ov != '0) [*4] |-> gate_out == '0)
    else $error("stop on fault left gates on");
  a_one_gate: assert property ((!stop_q && vds_ov[1]) [*4] |-> !gate_out[1])
    else $error("faulty gate still driven");
  a_restart_on: assert property ((restart_q && sync_lost) [*4] |-> stop_restart)
    else $error("no restart request");
  a_restart_off: assert property (!restart_q |-> !stop_restart)
    else $error("restart request without restart mode");

  c_irq: cover property ($rose(irq));
  c_restart: cover property ($rose(stop_restart));
  c_run_drop: cover property ($fell(run));
endmodule // bridge_fault_response_props

bind bridge_fault_response bridge_fault_response_props #(.HOLD_N(HOLD_N)) i_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .sys_err,
  .logic_regulator_uv, .sync_lost, .vds_ov, .gate_out, .run, .stop_restart, .irq);
`default_nettype wire

// *** verif/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model
  import fault_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // Bus master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Host pins
  output logic             demand_zero,
  output logic             host_reset_out_n
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    demand_zero = 1'b0;
    host_reset_out_n = 1'b1;
  end

  // One transfer; read data and error are taken at the completing edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      tb.chk(32'h0000_0000, 32'h0000_0001);
      tb.summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic demand_reset();
    @(posedge pclk) demand_zero <= 1'b1;
    repeat (3) @(posedge pclk);
    demand_zero <= 1'b0;
  endtask

  task automatic run_reset(input logic [31:0] c);
    logic [31:0] r;
    logic        e;
    apb(1'b1, CTRL_OFS, c & ~32'h0000_0001, r, e);
    apb(1'b1, CTRL_OFS, c | 32'h0000_0001, r, e);
  endtask

  task automatic set_rst(input logic v);
    @(posedge pclk) host_reset_out_n <= v;
  endtask
endmodule // host_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
  import fault_pkg::*;
;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel, penable, pwrite, pready, pslverr, demand_zero, host_reset_out_n;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [3:0]        pstrb;
  logic              sys_err, main_supply_uv, logic_regulator_uv, overtemp, sync_lost;
  logic              run, stop_restart, irq;
  logic [PHASES-1:0] bootstrap_uv;
  logic [GATES-1:0]  vds_ov, pwm_on, gate_in, gate_out;
  int                n_errors = 0;
  int                comparisons = 0;

  always #10 pclk = ~pclk;

  bridge_fault_response #(.HOLD_N(20)) i_bridge_fault_response (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .sys_err, .main_supply_uv, .logic_regulator_uv, .overtemp, .sync_lost, .bootstrap_uv, .vds_ov,
    .host_reset_out_n, .pwm_on, .demand_zero, .gate_in, .gate_out, .run, .stop_restart, .irq);
  host_model i_host_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .demand_zero, .host_reset_out_n);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic g(input logic [5:0] e);
    chk(32'(gate_out), 32'(e));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    i_host_model.apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    i_host_model.apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd(CTRL_OFS, 4'h0);
    rd(STATUS_OFS, 7'h00);
    wr(IRQ_MASK_OFS, 7'h7F);
    rd(IRQ_MASK_OFS, 7'h7F);
    i_host_model.apb(1'b0, 12'h020, 32'h0000_0000, r, e);
    chk(32'(e), 1'b1);
    wr(CTRL_OFS, 4'h1);
    cyc(2);
    chk(32'(run), 1'b1);
  endtask

  task automatic t_single();
    @(posedge pclk) vds_ov <= 6'h02;
    cyc(5);
    g(6'h3D);
    chk(32'(irq), 1'b1);
    @(posedge pclk) vds_ov <= 6'h00;
    cyc(5);
    g(6'h3D);
    @(posedge pclk) pwm_on <= 6'h02;
    cyc(3);
    g(6'h3F);
    pwm_on <= 6'h00;
    rd(IRQ_STAT_OFS, 7'h40);
    wr(IRQ_MASK_OFS, 7'h00);
    cyc(1);
    chk(32'(irq), 1'b0);
    wr(IRQ_MASK_OFS, 7'h7F);
    wr(IRQ_STAT_OFS, 7'h40);
    cyc(1);
    chk(32'(irq), 1'b0);
  endtask

  task automatic t_latch();
    wr(CTRL_OFS, 4'hB);
    @(posedge pclk) vds_ov <= 6'h04;
    cyc(5);
    g(6'h00);
    @(posedge pclk) vds_ov <= 6'h00;
    cyc(5);
    rd(STATUS_OFS, 7'h40);
    rd(STATUS_OFS, 7'h40);
    g(6'h00);
    wr(CTRL_OFS, 4'h3);
    rd(STATUS_OFS, 7'h40);
    cyc(2);
    g(6'h3F);
    @(posedge pclk) bootstrap_uv <= 3'h1;
    cyc(5);
    g(6'h00);
    @(posedge pclk) bootstrap_uv <= 3'h0;
    cyc(5);
    g(6'h00);
    i_host_model.run_reset(32'h0000_0003);
    cyc(2);
    g(6'h3F);
    wr(CTRL_OFS, 4'h1);
  endtask

  task automatic t_main_uv();
    wr(CTRL_OFS, 4'h9);
    @(posedge pclk) main_supply_uv <= 1'b1;
    cyc(5);
    g(6'h3F);
    @(posedge pclk) main_supply_uv <= 1'b0;
    cyc(5);
    rd(STATUS_OFS, 7'h02);
    i_host_model.demand_reset();
    rd(STATUS_OFS, 7'h00);
    wr(CTRL_OFS, 4'h1);
  endtask

  task automatic t_sync();
    @(posedge pclk) sync_lost <= 1'b1;
    cyc(5);
    g(6'h00);
    chk(32'(stop_restart), 1'b0);
    rd(DIAG_OFS, 7'h10);
    @(posedge pclk) sync_lost <= 1'b0;
    cyc(5);
    g(6'h00);
    i_host_model.demand_reset();
    cyc(2);
    g(6'h3F);
    wr(CTRL_OFS, 4'h5);
    @(posedge pclk) sync_lost <= 1'b1;
    cyc(5);
    chk(32'(stop_restart), 1'b1);
    g(6'h00);
    @(posedge pclk) sync_lost <= 1'b0;
    cyc(5);
    chk(32'(stop_restart), 1'b0);
    g(6'h3F);
    wr(CTRL_OFS, 4'h1);
  endtask

  // Regulator fault, or overtemperature under stop on fault
  task automatic t_hold(input logic ot);
    if (ot)
      wr(CTRL_OFS, 4'h3);
    i_host_model.set_rst(1'b0);
    logic_regulator_uv <= !ot;
    overtemp <= ot;
    cyc(5);
    g(6'h00);
    @(posedge pclk);
    logic_regulator_uv <= 1'b0;
    overtemp <= 1'b0;
    cyc(30);
    g(6'h00);
    i_host_model.set_rst(1'b1);
    cyc(12);
    g(6'h00);
    cyc(20);
    g(6'h3F);
    wr(CTRL_OFS, 4'h1);
  endtask

  task automatic t_sys();
    @(posedge pclk) sys_err <= 1'b1;
    cyc(5);
    chk(32'(run), 1'b0);
    g(6'h00);
    @(posedge pclk) sys_err <= 1'b0;
    cyc(5);
    g(6'h00);
    rd(STATUS_OFS, 7'h01);
    wr(CTRL_OFS, 4'h1);
    cyc(2);
    g(6'h3F);
    rd(STATUS_OFS, 7'h01);
    @(posedge pclk) presetn <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    rd(STATUS_OFS, 7'h00);
  endtask

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    sys_err = 1'b0;
    main_supply_uv = 1'b0;
    logic_regulator_uv = 1'b0;
    overtemp = 1'b0;
    sync_lost = 1'b0;
    bootstrap_uv = 3'h0;
    vds_ov = 6'h00;
    pwm_on = 6'h00;
    gate_in = 6'h3F;
    cyc(5);
    presetn <= 1'b1;
    t_regs();
    t_single();
    t_latch();
    t_main_uv();
    t_sync();
    t_hold(1'b0);
    t_hold(1'b1);
    t_sys();
    summarize();
  end
endmodule // tb
`default_nettype wire
